// File: rtl/fctrim_pkg.sv
// Package: register map, field layouts and reset values of the flash config block
package fctrim_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] FCT_ADDR_FREQ_HI = 12'hffa;
    localparam logic [11:0] FCT_ADDR_FREQ_LO = 12'hffb;
    localparam logic [11:0] FCT_ADDR_GUARD = 12'hff9;
    localparam logic [11:0] FCT_ADDR_TRIM_IDX = 12'hff6;
    localparam logic [11:0] FCT_ADDR_TRIM_DAT = 12'hff7;
    localparam logic [11:0] FCT_ADDR_USER_OPT0 = 12'hff4;
    localparam logic [11:0] FCT_ADDR_USER_OPT1 = 12'hff5;
    // ----------------------------------------
    // Reset values and layout
    // ----------------------------------------
    localparam logic [7:0] FCT_FREQ_RST = 8'h00;
    localparam logic [7:0] FCT_GUARD_RST = 8'h00;
    localparam logic [4:0] FCT_TRIM_IDX_RST = 5'h00;
    localparam int FCT_TRIM_BYTES = 32;
    localparam logic [6:0] FCT_TRIM_INFO_BASE = 7'h20;
    localparam int FCT_SECTOR_BYTES = 512;
    localparam logic [7:0] FCT_READ_NONE = 8'h00;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fct_bus_req_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
        logic wr;
    } fct_trim_wr_t;
endpackage : fctrim_pkg

// File: rtl/fctrim_store.sv
// Trim byte working store, cleared by reset and loaded from the factory copy on the load strobe
module fctrim_store
    import fctrim_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Factory copy and load strobe
    input wire logic [FCT_TRIM_BYTES*8-1:0] factory,
    input wire logic load,
    // Access port
    input wire logic [4:0] idx,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_q [FCT_TRIM_BYTES];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < FCT_TRIM_BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (load) begin
            for (int i = 0; i < FCT_TRIM_BYTES; i++) begin
                mem_q[i] <= factory[i*8 +: 8];
            end
        end else if (wr) begin
            mem_q[idx] <= wdata;
        end
    end

    assign rdata = mem_q[idx];
endmodule : fctrim_store

// File: rtl/fctrim_top.sv
// Flash configuration, option and trim access block
// Operation
// - One guard bit per 512-byte program memory sector.
// - Frequency value is high byte over low byte, sixteen bits.
// - User options come from first two program memory bytes.
// - Factory trim values survive program memory erase.
// - Working trim copies restored from factory on every reset.
// - Trim data write replaces the addressed working trim byte.
// - Trim data read returns the addressed working trim byte.
// - Trim indices reach only information locations 20 to 3F.
// - Serial number in information page survives mass erase.
module fctrim_top
    import fctrim_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic [11:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // Nonvolatile contents seen by this block
    input wire logic [15:0] PROG_MEM_OPT,
    input wire logic [FCT_TRIM_BYTES*8-1:0] INFO_TRIM_FACTORY,
    // Configuration toward flash controller
    output logic [15:0] FLASH_CLOCK_KHZ_VALUE,
    output logic [7:0] SECTOR_GUARD_BITS,
    output logic [15:0] USER_OPTION_BITS,
    output logic [6:0] TRIM_INFO_ADDR
);
    // ----------------------------------------
    // Register port decode
    // ----------------------------------------
    fct_bus_req_t req;
    logic [7:0] freq_hi_q;
    logic [7:0] freq_lo_q;
    logic [7:0] guard_q;
    logic [4:0] trim_idx_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic load_q;
    logic [7:0] trim_rdata;

    assign req = '{addr: REG_ADDR, wdata: REG_WDATA, wr: REG_WR, rd: REG_RD};

    wire hit_hi = req.addr == FCT_ADDR_FREQ_HI;
    wire hit_lo = req.addr == FCT_ADDR_FREQ_LO;
    wire hit_guard = req.addr == FCT_ADDR_GUARD;
    wire hit_idx = req.addr == FCT_ADDR_TRIM_IDX;
    wire hit_dat = req.addr == FCT_ADDR_TRIM_DAT;
    wire hit_opt0 = req.addr == FCT_ADDR_USER_OPT0;
    wire hit_opt1 = req.addr == FCT_ADDR_USER_OPT1;
    // Any mapped register; everything else reads as zero
    wire hit_any = hit_hi | hit_lo | hit_guard | hit_idx | hit_dat | hit_opt0 | hit_opt1;
    // only trim data write hits the store
    wire trim_wr = req.wr && hit_dat && !load_q;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // each byte written directly
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            freq_hi_q <= FCT_FREQ_RST;
            freq_lo_q <= FCT_FREQ_RST;
            guard_q <= FCT_GUARD_RST;
            trim_idx_q <= FCT_TRIM_IDX_RST;
        end else if (req.wr) begin
            if (hit_hi) begin
                freq_hi_q <= req.wdata;
            end
            if (hit_lo) begin
                freq_lo_q <= req.wdata;
            end
            if (hit_guard) begin
                guard_q <= req.wdata;
            end
            // Upper index bits dropped: index stays in 00-1F
            if (hit_idx) begin
                trim_idx_q <= req.wdata[4:0];
            end
        end
    end

    // restore copies one cycle after reset release
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    // factory copy is input only, never written
    fctrim_store u_store (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .factory(INFO_TRIM_FACTORY),
        .load(load_q),
        .idx(trim_idx_q),
        .wr(trim_wr),
        .wdata(req.wdata),
        .rdata(trim_rdata)
    );

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // addressed working byte on trim data read
    assign rdata_d = !req.rd ? FCT_READ_NONE :
                     hit_hi ? freq_hi_q :
                     hit_lo ? freq_lo_q :
                     hit_guard ? guard_q :
                     hit_idx ? {3'h0, trim_idx_q} :
                     hit_dat ? trim_rdata :
                     hit_opt0 ? PROG_MEM_OPT[7:0] :
                     hit_opt1 ? PROG_MEM_OPT[15:8] : FCT_READ_NONE;

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_q <= FCT_READ_NONE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign REG_RDATA = rdata_q;
    assign FLASH_CLOCK_KHZ_VALUE = {freq_hi_q, freq_lo_q};
    assign SECTOR_GUARD_BITS = guard_q;
    // options read live, so erasing page zero clears them
    assign USER_OPTION_BITS = PROG_MEM_OPT;
    assign TRIM_INFO_ADDR = FCT_TRIM_INFO_BASE | {2'b00, trim_idx_q};
    // serial bytes lie outside the trim window, never reachable

    // ----------------------------------------
    // Frequency checks
    // ----------------------------------------
    property p_freq_concat;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_FREQ_HI) |=> FLASH_CLOCK_KHZ_VALUE[15:8] == $past(REG_WDATA);
    endproperty
    a_freq_concat: assert property (p_freq_concat) else $error("freq high byte not applied");

    property p_freq_lo;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_FREQ_LO) |=> REG_RD && REG_ADDR == FCT_ADDR_FREQ_LO
            |=> REG_RDATA == $past(REG_WDATA, 2);
    endproperty
    a_freq_lo: assert property (p_freq_lo) else $error("freq low byte readback wrong");

    property p_freq_lo_out;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_FREQ_LO) |=> FLASH_CLOCK_KHZ_VALUE[7:0] == $past(REG_WDATA);
    endproperty
    a_freq_lo_out: assert property (p_freq_lo_out) else $error("freq low byte not applied");

    property p_freq_hi_hold;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_FREQ_LO) |=> $stable(FLASH_CLOCK_KHZ_VALUE[15:8]);
    endproperty
    a_freq_hi_hold: assert property (p_freq_hi_hold) else $error("freq high byte moved on low write");

    property p_freq_lo_hold;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_FREQ_HI) |=> $stable(FLASH_CLOCK_KHZ_VALUE[7:0]);
    endproperty
    a_freq_lo_hold: assert property (p_freq_lo_hold) else $error("freq low byte moved on high write");

    property p_freq_hi_rd;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && REG_ADDR == FCT_ADDR_FREQ_HI) |=> REG_RDATA == $past(FLASH_CLOCK_KHZ_VALUE[15:8]);
    endproperty
    a_freq_hi_rd: assert property (p_freq_hi_rd) else $error("freq high byte readback wrong");

    property p_freq_keep;
        @(posedge REF_CLK) disable iff (!RST_B)
        !(REG_WR && (hit_hi || hit_lo)) |=> $stable(FLASH_CLOCK_KHZ_VALUE);
    endproperty
    a_freq_keep: assert property (p_freq_keep) else $error("freq value changed without write");

    // ----------------------------------------
    // Guard register checks
    // ----------------------------------------

    property p_guard;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_GUARD) |=> SECTOR_GUARD_BITS == $past(REG_WDATA);
    endproperty
    a_guard: assert property (p_guard) else $error("guard bits not stored");

    property p_guard_keep;
        @(posedge REF_CLK) disable iff (!RST_B)
        !(REG_WR && hit_guard) |=> $stable(SECTOR_GUARD_BITS);
    endproperty
    a_guard_keep: assert property (p_guard_keep) else $error("guard bits changed without write");

    property p_guard_rd;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && hit_guard) |=> REG_RDATA == $past(SECTOR_GUARD_BITS);
    endproperty
    a_guard_rd: assert property (p_guard_rd) else $error("guard readback wrong");

    // ----------------------------------------
    // Trim checks
    // ----------------------------------------

    property p_trim_rt;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && REG_ADDR == FCT_ADDR_TRIM_DAT && !load_q) ##1
            (REG_RD && REG_ADDR == FCT_ADDR_TRIM_DAT) |=> REG_RDATA == $past(REG_WDATA, 2);
    endproperty
    a_trim_rt: assert property (p_trim_rt) else $error("trim byte not replaced");

    property p_trim_rd;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && REG_ADDR == FCT_ADDR_TRIM_DAT) |=> REG_RDATA == $past(trim_rdata);
    endproperty
    a_trim_rd: assert property (p_trim_rd) else $error("trim read wrong byte");

    property p_trim_wr;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && hit_dat && !load_q) |=> trim_rdata == $past(REG_WDATA);
    endproperty
    a_trim_wr: assert property (p_trim_wr) else $error("trim write not stored");

    property p_trim_rd_keep;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && hit_dat && !load_q) |=> $stable(trim_rdata);
    endproperty
    a_trim_rd_keep: assert property (p_trim_rd_keep) else $error("trim read disturbed byte");

    property p_idx_wr;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_WR && hit_idx) |=> TRIM_INFO_ADDR == {2'b01, $past(REG_WDATA[4:0])};
    endproperty
    a_idx_wr: assert property (p_idx_wr) else $error("trim index not applied");

    property p_idx_rd;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && hit_idx) |=> REG_RDATA == {3'h0, $past(TRIM_INFO_ADDR[4:0])};
    endproperty
    a_idx_rd: assert property (p_idx_rd) else $error("trim index readback wrong");

    property p_idx_hold;
        @(posedge REF_CLK) disable iff (!RST_B)
        !(REG_WR && hit_idx) |=> $stable(TRIM_INFO_ADDR);
    endproperty
    a_idx_hold: assert property (p_idx_hold) else $error("trim index changed without write");

    property p_restore;
        @(posedge REF_CLK) disable iff (!RST_B)
        load_q |=> trim_rdata == $past(INFO_TRIM_FACTORY[trim_idx_q*8 +: 8]);
    endproperty
    a_restore: assert property (p_restore) else $error("trim not restored");

    property p_load_once;
        @(posedge REF_CLK) disable iff (!RST_B)
        load_q |=> !load_q;
    endproperty
    a_load_once: assert property (p_load_once) else $error("trim load lasted too long");

    property p_window;
        @(posedge REF_CLK) disable iff (!RST_B)
        TRIM_INFO_ADDR >= 7'h20 && TRIM_INFO_ADDR <= 7'h3f;
    endproperty
    a_window: assert property (p_window) else $error("trim address outside window");

    // ----------------------------------------
    // Read port checks
    // ----------------------------------------

    property p_opt;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && REG_ADDR == FCT_ADDR_USER_OPT1) |=> REG_RDATA == $past(PROG_MEM_OPT[15:8]);
    endproperty
    a_opt: assert property (p_opt) else $error("user option read wrong");

    property p_opt0;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && hit_opt0) |=> REG_RDATA == $past(PROG_MEM_OPT[7:0]);
    endproperty
    a_opt0: assert property (p_opt0) else $error("user option low byte read wrong");

    property p_rd_idle;
        @(posedge REF_CLK) disable iff (!RST_B)
        !REG_RD |=> REG_RDATA == FCT_READ_NONE;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");

    property p_rd_unmapped;
        @(posedge REF_CLK) disable iff (!RST_B)
        (REG_RD && !hit_any) |=> REG_RDATA == FCT_READ_NONE;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule : fctrim_top

// File: sim/testbench.sv
// Self-checking bench for the flash config and trim access block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fctrim_pkg::*;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic [11:0] REG_ADDR = 12'h000;
    logic [7:0] REG_WDATA = 8'h00;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [15:0] PROG_MEM_OPT = 16'h0000;
    logic [FCT_TRIM_BYTES*8-1:0] INFO_TRIM_FACTORY;
    logic [7:0] REG_RDATA;
    logic [15:0] FLASH_CLOCK_KHZ_VALUE;
    logic [7:0] SECTOR_GUARD_BITS;
    logic [15:0] USER_OPTION_BITS;
    logic [6:0] TRIM_INFO_ADDR;
    logic [7:0] rv;
    logic [7:0] ix;
    int num_errors = 0;
    int checks_done = 0;

    fctrim_top dut (.REF_CLK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .PROG_MEM_OPT,
        .INFO_TRIM_FACTORY, .FLASH_CLOCK_KHZ_VALUE, .SECTOR_GUARD_BITS, .USER_OPTION_BITS, .TRIM_INFO_ADDR);

    always #2 REF_CLK = ~REF_CLK;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] fb(input int i);
        return 8'(i * 7 + 'h13);
    endfunction : fb

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic do_reset;
        @(posedge REF_CLK);
        RST_B <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RST_B <= 1'b1;
        // Trim load takes the first edge after release
        repeat (2) @(posedge REF_CLK);
    endtask : do_reset

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask : wr

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        d = REG_RDATA;
    endtask : rd

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_freq;
        chk("freq_rst", 16'h0000, FLASH_CLOCK_KHZ_VALUE);
        wr(FCT_ADDR_FREQ_HI, 8'h4e);
        chk("freq_hi_only", 16'h4e00, FLASH_CLOCK_KHZ_VALUE);
        // 4e20 is 20000 kHz, the top of the supported range
        wr(FCT_ADDR_FREQ_LO, 8'h20);
        chk("freq_value", 16'h4e20, FLASH_CLOCK_KHZ_VALUE);
        rd(FCT_ADDR_FREQ_LO, rv);
        chk("freq_lo_rd", 16'h0020, {8'h00, rv});
        rd(FCT_ADDR_FREQ_HI, rv);
        chk("freq_hi_rd", 16'h004e, {8'h00, rv});
    endtask : t_freq

    task automatic t_guard;
        chk("guard_rst", 16'h0000, {8'h00, SECTOR_GUARD_BITS});
        wr(FCT_ADDR_GUARD, 8'ha5);
        chk("guard_out", 16'h00a5, {8'h00, SECTOR_GUARD_BITS});
        rd(FCT_ADDR_GUARD, rv);
        chk("guard_rd", 16'h00a5, {8'h00, rv});
        // Smallest part: only the two low bits guard a sector
        wr(FCT_ADDR_GUARD, 8'h03);
        chk("guard_small", 16'h0003, {8'h00, SECTOR_GUARD_BITS});
    endtask : t_guard

    task automatic t_opt;
        @(posedge REF_CLK);
        PROG_MEM_OPT <= 16'hc33c;
        wr(FCT_ADDR_USER_OPT0, 8'h00);
        chk("opt_out", 16'hc33c, USER_OPTION_BITS);
        rd(FCT_ADDR_USER_OPT0, rv);
        chk("opt0_rd", 16'h003c, {8'h00, rv});
        rd(FCT_ADDR_USER_OPT1, rv);
        chk("opt1_rd", 16'h00c3, {8'h00, rv});
    endtask : t_opt

    task automatic t_trim;
        // Index 2a wraps to 0a: only five index bits exist
        for (int n = 0; n < 3; n++) begin
            ix = (n == 0) ? 8'h00 : (n == 1) ? 8'h1f : 8'h2a;
            wr(FCT_ADDR_TRIM_IDX, ix);
            chk("trim_info", {9'h000, 7'h20 + {2'b00, ix[4:0]}}, {9'h000, TRIM_INFO_ADDR});
            rd(FCT_ADDR_TRIM_IDX, rv);
            chk("trim_idx_rd", {11'h000, ix[4:0]}, {8'h00, rv});
            rd(FCT_ADDR_TRIM_DAT, rv);
            chk("trim_rd", {8'h00, fb(int'(ix[4:0]))}, {8'h00, rv});
            wr(FCT_ADDR_TRIM_DAT, ~fb(int'(ix[4:0])));
            rd(FCT_ADDR_TRIM_DAT, rv);
            chk("trim_wr", {8'h00, ~fb(int'(ix[4:0]))}, {8'h00, rv});
        end
        wr(FCT_ADDR_TRIM_IDX, 8'h01);
        rd(FCT_ADDR_TRIM_DAT, rv);
        chk("trim_other", {8'h00, fb(1)}, {8'h00, rv});
        do_reset();
        wr(FCT_ADDR_TRIM_IDX, 8'h1f);
        rd(FCT_ADDR_TRIM_DAT, rv);
        chk("trim_restore", {8'h00, fb(31)}, {8'h00, rv});
        chk("freq_after_rst", 16'h0000, FLASH_CLOCK_KHZ_VALUE);
    endtask : t_trim

    task automatic t_unmapped;
        wr(12'h123, 8'hff);
        rd(12'h123, rv);
        chk("unmapped_rd", 16'h0000, {8'h00, rv});
        chk("guard_kept", 16'h0000, {8'h00, SECTOR_GUARD_BITS});
    endtask : t_unmapped

    // Strobes back to back, no idle cycle between them
    task automatic t_b2b;
        @(posedge REF_CLK);
        REG_ADDR <= FCT_ADDR_FREQ_LO;
        REG_WDATA <= 8'h88;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        chk("b2b_freq", 16'h0088, {8'h00, REG_RDATA});
        @(posedge REF_CLK);
        REG_ADDR <= FCT_ADDR_TRIM_IDX;
        REG_WDATA <= 8'h05;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_ADDR <= FCT_ADDR_TRIM_DAT;
        REG_WDATA <= 8'haa;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        chk("b2b_trim", 16'h00aa, {8'h00, REG_RDATA});
        @(posedge REF_CLK);
        #1;
        chk("rdata_idle", 16'h0000, {8'h00, REG_RDATA});
    endtask : t_b2b

    // Trim data write in the load cycle must lose to the restore
    task automatic t_load_wr;
        @(posedge REF_CLK);
        RST_B <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        RST_B <= 1'b1;
        REG_ADDR <= FCT_ADDR_TRIM_DAT;
        REG_WDATA <= 8'h5a;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        #1;
        rd(FCT_ADDR_TRIM_DAT, rv);
        chk("load_wr_ignored", {8'h00, fb(0)}, {8'h00, rv});
    endtask : t_load_wr

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        for (int i = 0; i < FCT_TRIM_BYTES; i++) begin
            INFO_TRIM_FACTORY[8*i +: 8] = fb(i);
        end
        do_reset();
        t_freq();
        t_guard();
        t_opt();
        t_trim();
        t_unmapped();
        t_b2b();
        t_load_wr();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge REF_CLK);
        num_errors++;
        test_done();
    end
endmodule : testbench
